//--- lsp_pkg.sv
// package: constants, enums and structs for the load sequencer and protection block
package lsp_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned STEP_MIN_MS     = 500;
  localparam int unsigned STEP_MAX_S      = 99999;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned NUM_LISTS       = 4;
  localparam int unsigned NUM_STEPS       = 10;
  localparam int unsigned NUM_LOCS        = 10;
  localparam int unsigned VAL_W           = 16;
  localparam int unsigned DUR_W           = 27;
  localparam int unsigned CNT_W           = 8;
  localparam logic [DUR_W-1:0] DUR_MIN    = DUR_W'(STEP_MIN_MS);
  localparam logic [DUR_W-1:0] DUR_MAX    = DUR_W'(STEP_MAX_S * MS_PER_S);
  localparam logic [VAL_W-1:0] DEF_ICEIL  = 16'h7530;
  localparam logic [VAL_W-1:0] DEF_PCEIL  = 16'h00C8;
  localparam logic [VAL_W-1:0] DEF_VTHR   = 16'h0000;
  localparam logic [VAL_W-1:0] OV_LEVEL   = 16'hEA60;

  typedef enum logic [1:0] {
    LSP_CC,
    LSP_CV,
    LSP_CR,
    LSP_CP
  } lsp_mode_e;

  typedef enum logic [1:0] {
    LSP_ED_NONE,
    LSP_ED_PARAM,
    LSP_ED_STEP
  } lsp_edit_e;

  typedef struct packed {
    lsp_mode_e        mode;
    logic [VAL_W-1:0] value;
    logic [DUR_W-1:0] dur_ms;
  } lsp_step_s;

  typedef struct packed {
    logic             input_on;
    lsp_mode_e        mode;
    logic [VAL_W-1:0] i_ceil;
    logic [VAL_W-1:0] p_ceil;
    logic [VAL_W-1:0] v_thr;
  } lsp_param_s;

  typedef struct packed {
    logic ov;
    logic oc;
    logic op;
    logic ot;
    logic rv;
  } lsp_fault_s;

  localparam lsp_param_s PARAM_DEFAULT = '{input_on: 1'b0, mode: LSP_CC,
                                          i_ceil: DEF_ICEIL, p_ceil: DEF_PCEIL,
                                          v_thr: DEF_VTHR};

endpackage : lsp_pkg

//--- lsp_top.sv
// load list sequencer, input gating, measurement and latched protection
`timescale 1ns/1ps
module lsp_top
  import lsp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  input  wire logic             cmd_remote,
  input  wire logic             cmd_input_set,
  input  wire logic             cmd_input_val,
  input  wire logic             cmd_mode_set,
  input  wire lsp_mode_e        cmd_mode,
  input  wire logic             cmd_param_set,
  input  wire lsp_param_s       cmd_param,
  input  wire logic             cmd_save,
  input  wire logic             cmd_recall,
  input  wire logic [3:0]       cmd_loc,
  input  wire logic             cmd_step_wr,
  input  wire logic [1:0]       cmd_list,
  input  wire logic [3:0]       cmd_step,
  input  wire lsp_step_s        cmd_step_data,
  input  wire logic             cmd_step_exit,
  input  wire logic             cmd_list_cfg,
  input  wire logic [3:0]       cmd_list_len,
  input  wire logic [CNT_W-1:0] cmd_list_count,
  input  wire logic             cmd_list_link_en,
  input  wire logic [1:0]       cmd_list_link,
  input  wire logic             cmd_list_run,
  input  wire logic             cmd_ocp_set,
  input  wire logic             cmd_ocp_en,
  input  wire logic [VAL_W-1:0] cmd_ocp_level,
  input  wire logic [DUR_W-1:0] cmd_ocp_delay_ms,
  input  wire logic [DUR_W-1:0] cmd_opp_delay_ms,
  input  wire logic             cmd_aux_set,
  input  wire logic             cmd_knob_en,
  input  wire logic             cmd_beep_en,
  input  wire logic             clear_esc,
  input  wire logic             clear_remote,
  input  wire logic [VAL_W-1:0] meas_v,
  input  wire logic [VAL_W-1:0] meas_i,
  input  wire logic             over_temp,
  input  wire logic             reverse_pol,
  output lsp_param_s            cur_param,
  output logic                  load_enable,
  output lsp_mode_e             reg_mode,
  output logic [VAL_W-1:0]      reg_value,
  output logic                  power_clamp,
  output logic                  list_active,
  output logic [1:0]            list_no,
  output logic [3:0]            step_no,
  output logic [2*VAL_W-1:0]    meas_p,
  output logic [VAL_W-1:0]      meas_r,
  output logic                  cmd_refused,
  output logic                  beep,
  output logic                  prot_latched,
  output lsp_fault_s            fault_flags,
  output logic                  voltage_fault_summary,
  output logic                  protection_summary,
  output logic                  knob_en,
  output logic                  key_sound_en
);

  // parameter store and list store
  lsp_param_s       loc_mem [NUM_LOCS];
  lsp_step_s        stp_mem [NUM_LISTS][NUM_STEPS];
  lsp_step_s        stp_buf [NUM_STEPS];
  logic [3:0]       len_mem [NUM_LISTS];
  logic [CNT_W-1:0] cnt_mem [NUM_LISTS];
  logic             lke_mem [NUM_LISTS];
  logic [1:0]       lnk_mem [NUM_LISTS];

  lsp_param_s       par_ff,  nxt_par;
  logic             boot_ff;
  logic             edit_ff;
  logic [1:0]       edit_list_ff;
  logic             run_ff,  nxt_run;
  logic [1:0]       lst_ff,  nxt_lst;
  logic [3:0]       stp_ff,  nxt_stp;
  logic [CNT_W-1:0] rep_ff,  nxt_rep;
  logic [DUR_W-1:0] ms_ff,   nxt_ms;
  logic [31:0]      tick_ff;
  logic             ms_tick;
  logic             ocp_en_ff;
  logic [VAL_W-1:0] ocp_lvl_ff;
  logic [DUR_W-1:0] ocp_dly_ff, opp_dly_ff;
  logic [DUR_W-1:0] oc_ms_ff, op_ms_ff;
  lsp_fault_s       flt_ff, nxt_flt, cond;
  logic             lat_ff;
  // unwritten locations read back as defaults, never as unknown words
  logic [NUM_LOCS-1:0] loc_vld_ff;

  function automatic logic dur_ok(input logic [DUR_W-1:0] d);
    return (d >= DUR_MIN) && (d <= DUR_MAX);
  endfunction : dur_ok

  function automatic logic mode_ok(input lsp_mode_e m);
    return m != LSP_CP;
  endfunction : mode_ok

  wire logic       accept   = !lat_ff;
  wire logic       chg_ok   = accept && (cmd_remote || !par_ff.input_on);
  wire lsp_step_s  cur_step = stp_mem[lst_ff][stp_ff];
  wire logic [VAL_W*2-1:0] pwr = meas_v * meas_i;

  assign ms_tick = (tick_ff == TICK_CYCLES - 1);

  // fault conditions; ceiling on power comes from the current parameter set
  always_comb begin
    cond.ov = meas_v > OV_LEVEL;
    cond.oc = ocp_en_ff && (oc_ms_ff >= ocp_dly_ff) && (meas_i > ocp_lvl_ff);
    cond.op = (pwr > {16'h0000, par_ff.p_ceil}) && (op_ms_ff >= opp_dly_ff);
    cond.ot = over_temp;
    cond.rv = reverse_pol;
  end

  always_comb begin
    nxt_flt = flt_ff;
    // a clear only drops flags whose condition is gone; set wins over clear
    if (clear_esc || clear_remote) nxt_flt = '0;
    nxt_flt = nxt_flt | cond;
  end

  always_comb begin
    nxt_par = par_ff;
    if (boot_ff) begin
      nxt_par = loc_vld_ff[0] ? loc_mem[0] : PARAM_DEFAULT;
    end else if (accept) begin
      if (cmd_param_set) nxt_par = cmd_param;
      if (cmd_mode_set && chg_ok) nxt_par.mode = cmd_mode;
      if (cmd_recall && chg_ok && cmd_loc < 4'(NUM_LOCS)) begin
        nxt_par = loc_vld_ff[cmd_loc] ? loc_mem[cmd_loc] : PARAM_DEFAULT;
      end
      // input switch touches only the input bit, levels stay as they are
      if (cmd_input_set) nxt_par.input_on = cmd_input_val;
    end
    if (|cond) nxt_par.input_on = 1'b0;
  end

  // list sequencer
  always_comb begin
    nxt_run = run_ff;
    nxt_lst = lst_ff;
    nxt_stp = stp_ff;
    nxt_rep = rep_ff;
    nxt_ms  = ms_ff;
    if (!run_ff) begin
      if (cmd_list_run && chg_ok) begin
        nxt_run = 1'b1;
        nxt_lst = cmd_list;
        nxt_stp = '0;
        nxt_rep = '0;
        nxt_ms  = '0;
      end
    end else if (|cond || !par_ff.input_on) begin
      nxt_run = 1'b0;
    end else if (ms_tick) begin
      nxt_ms = ms_ff + 1'b1;
      if (nxt_ms >= cur_step.dur_ms) begin
        nxt_ms = '0;
        if (stp_ff + 1'b1 < len_mem[lst_ff]) begin
          nxt_stp = stp_ff + 1'b1;
        end else if (rep_ff < cnt_mem[lst_ff]) begin
          nxt_stp = '0;
          nxt_rep = rep_ff + 1'b1;
        end else if (lke_mem[lst_ff]) begin
          nxt_lst = lnk_mem[lst_ff];
          nxt_stp = '0;
          nxt_rep = '0;
        end else begin
          nxt_run = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      par_ff  <= PARAM_DEFAULT;
      boot_ff <= 1'b1;
      flt_ff  <= '0;
      lat_ff  <= 1'b0;
      run_ff  <= 1'b0;
      lst_ff  <= '0;
      stp_ff  <= '0;
      rep_ff  <= '0;
      ms_ff   <= '0;
      tick_ff <= '0;
    end else if (clk_en) begin
      par_ff  <= nxt_par;
      boot_ff <= 1'b0;
      flt_ff  <= nxt_flt;
      lat_ff  <= (|cond) || (lat_ff && !(clear_esc || clear_remote));
      run_ff  <= nxt_run;
      lst_ff  <= nxt_lst;
      stp_ff  <= nxt_stp;
      rep_ff  <= nxt_rep;
      ms_ff   <= nxt_ms;
      tick_ff <= ms_tick ? '0 : tick_ff + 1;
    end
  end

  // storage and protection timers; memories carry no reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edit_ff      <= 1'b0;
      edit_list_ff <= '0;
      loc_vld_ff   <= '0;
      ocp_en_ff    <= 1'b0;
      ocp_lvl_ff   <= DEF_ICEIL;
      ocp_dly_ff   <= '0;
      opp_dly_ff   <= '0;
      oc_ms_ff     <= '0;
      op_ms_ff     <= '0;
      knob_en      <= 1'b1;
      key_sound_en <= 1'b1;
    end else if (clk_en) begin
      if (accept && cmd_step_wr && cmd_step < 4'(NUM_STEPS) && dur_ok(cmd_step_data.dur_ms)
          && mode_ok(cmd_step_data.mode)) begin
        stp_buf[cmd_step] <= cmd_step_data;
        edit_ff           <= 1'b1;
        edit_list_ff      <= cmd_list;
      end
      if (cmd_step_exit && edit_ff) begin
        stp_mem[edit_list_ff] <= stp_buf;
        edit_ff               <= 1'b0;
      end
      if (accept && cmd_list_cfg && cmd_list_len <= 4'(NUM_STEPS)) begin
        len_mem[cmd_list] <= cmd_list_len;
        cnt_mem[cmd_list] <= cmd_list_count;
        lke_mem[cmd_list] <= cmd_list_link_en;
        lnk_mem[cmd_list] <= cmd_list_link;
      end
      if (accept && cmd_save && cmd_loc < 4'(NUM_LOCS)) begin
        loc_mem[cmd_loc]    <= par_ff;
        loc_vld_ff[cmd_loc] <= 1'b1;
      end
      if (accept && cmd_ocp_set && cmd_remote) begin
        ocp_en_ff  <= cmd_ocp_en;
        ocp_lvl_ff <= cmd_ocp_level;
        ocp_dly_ff <= cmd_ocp_delay_ms;
        opp_dly_ff <= cmd_opp_delay_ms;
      end
      if (accept && cmd_aux_set) begin
        knob_en      <= cmd_knob_en;
        key_sound_en <= cmd_beep_en;
      end
      if (meas_i <= ocp_lvl_ff) oc_ms_ff <= '0;
      else if (ms_tick && oc_ms_ff != DUR_MAX) oc_ms_ff <= oc_ms_ff + 1'b1;
      if (pwr <= {16'h0000, par_ff.p_ceil}) op_ms_ff <= '0;
      else if (ms_tick && op_ms_ff != DUR_MAX) op_ms_ff <= op_ms_ff + 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur_param             <= PARAM_DEFAULT;
      load_enable           <= 1'b0;
      reg_mode              <= LSP_CC;
      reg_value             <= '0;
      power_clamp           <= 1'b0;
      list_active           <= 1'b0;
      list_no               <= '0;
      step_no               <= '0;
      meas_p                <= '0;
      meas_r                <= '0;
      cmd_refused           <= 1'b0;
      beep                  <= 1'b0;
      prot_latched          <= 1'b0;
      fault_flags           <= '0;
      voltage_fault_summary <= 1'b0;
      protection_summary    <= 1'b0;
    end else if (clk_en) begin
      cur_param   <= par_ff;
      load_enable <= par_ff.input_on && !lat_ff && (meas_v >= par_ff.v_thr);
      if (meas_i >= par_ff.i_ceil) reg_mode <= LSP_CC;
      else reg_mode <= run_ff ? cur_step.mode : par_ff.mode;
      reg_value   <= (meas_i >= par_ff.i_ceil) ? par_ff.i_ceil
                     : (run_ff ? cur_step.value : reg_value);
      power_clamp <= pwr > {16'h0000, par_ff.p_ceil};
      list_active <= run_ff;
      list_no     <= lst_ff;
      step_no     <= stp_ff;
      meas_p      <= pwr;
      meas_r      <= (meas_i == '0) ? '1 : VAL_W'(meas_v / meas_i);
      cmd_refused <= (cmd_mode_set || cmd_list_run || cmd_recall) && !chg_ok;
      beep        <= |cond;
      prot_latched <= lat_ff;
      fault_flags <= flt_ff;
      voltage_fault_summary <= flt_ff.ov || flt_ff.rv;
      protection_summary    <= flt_ff.oc || flt_ff.op || flt_ff.ot;
    end
  end

endmodule : lsp_top

//--- lsp_chk_sva.sv
// assertion checker for the load sequencer and protection block
`timescale 1ns/1ps
module lsp_chk
  import lsp_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             nrst,
  input wire logic             clk_en,
  input wire logic [VAL_W-1:0] meas_v,
  input wire logic             over_temp,
  input wire logic             reverse_pol,
  input wire lsp_param_s       cur_param,
  input wire logic             load_enable,
  input wire lsp_mode_e        reg_mode,
  input wire logic             list_active,
  input wire logic             prot_latched,
  input wire lsp_fault_s       fault_flags,
  input wire logic             voltage_fault_summary,
  input wire logic             protection_summary
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // a condition only counts as a new trip while nothing is latched yet
  sequence s_trip(cond);
    clk_en && !prot_latched && cond;
  endsequence

  a_ot_trip: assert property (s_trip(over_temp) |-> ##[1:3] fault_flags.ot)
    else $error("overtemperature flag not set");
  a_rv_trip: assert property (s_trip(reverse_pol) |-> ##[1:3] fault_flags.rv)
    else $error("reverse flag not set");
  a_ov_trip: assert property (s_trip(meas_v > OV_LEVEL) |-> ##[1:3] fault_flags.ov)
    else $error("overvoltage flag not set");
  a_volt_sum: assert property (voltage_fault_summary == (fault_flags.ov || fault_flags.rv))
    else $error("voltage summary mismatch");
  a_prot_sum: assert property (protection_summary == (fault_flags.oc || fault_flags.op || fault_flags.ot))
    else $error("protection summary mismatch");
  a_latch_off: assert property (prot_latched |-> !load_enable && !cur_param.input_on)
    else $error("input still on while latched");
  a_flag_latch: assert property ((fault_flags != '0) |-> prot_latched)
    else $error("flag set without latch");
  a_flag_hold: assert property (fault_flags.rv && reverse_pol |=> fault_flags.rv)
    else $error("reverse flag dropped while present");
  a_list_mode: assert property (list_active |-> reg_mode != LSP_CP)
    else $error("list step in power mode");
endmodule : lsp_chk

//--- lsp_host.sv
// partner model of front panel and remote host: command fields and strobes
`timescale 1ns/1ps
module lsp_host
  import lsp_pkg::*;
(
  input  wire logic ref_clk,
  output logic       clk_en,
  output logic       cmd_remote,
  output logic       cmd_input_set,
  output logic       cmd_input_val,
  output logic       cmd_mode_set,
  output lsp_mode_e  cmd_mode,
  output logic       cmd_param_set,
  output lsp_param_s cmd_param,
  output logic       cmd_save,
  output logic       cmd_recall,
  output logic [3:0] cmd_loc,
  output logic       cmd_step_wr,
  output logic [1:0] cmd_list,
  output logic [3:0] cmd_step,
  output lsp_step_s  cmd_step_data,
  output logic       cmd_step_exit,
  output logic       cmd_list_cfg,
  output logic [3:0] cmd_list_len,
  output logic [7:0] cmd_list_count,
  output logic       cmd_list_link_en,
  output logic [1:0] cmd_list_link,
  output logic       cmd_list_run,
  output logic       cmd_aux_set,
  output logic       cmd_knob_en,
  output logic       cmd_beep_en,
  output logic       clear_esc,
  output logic       clear_remote
);
  logic [11:0] stb = 12'h000;

  // escape key, remote clear and reset (nrst low) are the only three ways out of the latch
  assign {clear_remote, clear_esc, cmd_aux_set, cmd_list_run, cmd_list_cfg, cmd_step_exit,
          cmd_step_wr, cmd_recall, cmd_save, cmd_param_set, cmd_mode_set,
          cmd_input_set} = stb;

  initial begin
    clk_en = 1'b1;
    cmd_remote = 1'b0;
    cmd_mode = LSP_CC;
    {cmd_input_val, cmd_param, cmd_loc, cmd_list, cmd_step, cmd_step_data} = '0;
    {cmd_list_len, cmd_list_count, cmd_list_link_en, cmd_list_link} = '0;
    {cmd_knob_en, cmd_beep_en} = 2'b00;
  end

  // fields must already be set; strobe spans exactly one rising edge
  task automatic go(int k);
    @(negedge ref_clk);
    stb[k] = 1'b1;
    @(negedge ref_clk);
    stb = 12'h000;
  endtask : go
endmodule : lsp_host

//--- testbench.sv
// self-checking bench for the load sequencer and protection block
`timescale 1ns/1ps
module testbench;
  import lsp_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en, cmd_remote, cmd_input_set, cmd_input_val, cmd_mode_set, cmd_param_set;
  logic cmd_save, cmd_recall, cmd_step_wr, cmd_step_exit, cmd_list_cfg, cmd_list_link_en;
  logic cmd_list_run, cmd_aux_set, cmd_knob_en, cmd_beep_en, clear_esc, clear_remote;
  logic [3:0] cmd_loc, cmd_step, cmd_list_len, step_no;
  logic [1:0] cmd_list, cmd_list_link, list_no;
  logic [7:0] cmd_list_count;
  logic [15:0] meas_v = 16'h0000, meas_i = 16'h0000, reg_value, meas_r;
  logic [31:0] meas_p;
  logic over_temp = 1'b0, reverse_pol = 1'b0, load_enable, power_clamp, list_active;
  logic cmd_refused, beep, prot_latched, voltage_fault_summary, protection_summary;
  logic knob_en, key_sound_en;
  lsp_mode_e cmd_mode, reg_mode;
  lsp_param_s cmd_param, cur_param, p1;
  lsp_step_s cmd_step_data;
  lsp_fault_s fault_flags;
  int fails = 0, checked = 0, cyc = 0;
  logic cmd_ocp_set = 1'b0, cmd_ocp_en = 1'b0;
  logic [15:0] cmd_ocp_level = 16'h0000;
  logic [26:0] cmd_ocp_delay_ms = 27'h0000000, cmd_opp_delay_ms = 27'h0000000;

  always #25 ref_clk = ~ref_clk;

  lsp_host host_u (.*);
  lsp_top #(.TICK_CYCLES(4)) dut_u (.*);

  task automatic tk(int n);
    repeat (n) @(negedge ref_clk);
  endtask : tk

  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    checked++;
    if (exp !== got) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic fault(int k);
    lsp_fault_s ef;
    ef = (k == 0) ? 5'h02 : (k == 1) ? 5'h01 : 5'h10;
    over_temp = (k == 0);
    reverse_pol = (k == 1);
    if (k == 2)
      meas_v = 16'hEA61;
    tk(4);
    chk("trip", {1'b1, ef, 2'b00},
        {prot_latched, fault_flags, load_enable, cur_param.input_on});
    chk("summary", {k != 0, k == 0}, {voltage_fault_summary, protection_summary});
    host_u.go(0);
    tk(3);
    chk("ignored", 1'b0, cur_param.input_on);
    host_u.go(10 + k % 2);
    tk(3);
    chk("relatch", 1'b1, prot_latched);
    over_temp = 1'b0;
    reverse_pol = 1'b0;
    meas_v = 16'h0064;
    host_u.go(10 + k % 2);
    tk(3);
    chk("cleared", 6'h00, {prot_latched, fault_flags});
  endtask : fault

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    tk(8);
    chk("dflt", PARAM_DEFAULT, cur_param);
    chk("rst_mode", LSP_CC, reg_mode);
    chk("rst_flags", 6'h00, {prot_latched, fault_flags});
    tk(8);
    nrst = 1'b1;
    tk(3);
    p1 = '{input_on: 1'b0, mode: LSP_CV, i_ceil: DEF_ICEIL, p_ceil: 16'hFFFF, v_thr: 16'h0064};
    host_u.cmd_param = p1;
    host_u.go(2);
    host_u.cmd_loc = 4'h4;
    host_u.go(3);
    host_u.cmd_param = PARAM_DEFAULT;
    host_u.go(2);
    host_u.go(4);
    tk(3);
    chk("recall", p1, cur_param);
    host_u.cmd_loc = 4'hA;
    host_u.go(4);
    tk(3);
    chk("recall_10", p1, cur_param);
    $display("test store done");
    meas_v = 16'h0063;
    meas_i = 16'h0005;
    host_u.cmd_input_val = 1'b1;
    host_u.go(0);
    tk(3);
    chk("on_keep", {1'b1, LSP_CV, 1'b0}, {cur_param.input_on, reg_mode, load_enable});
    meas_v = 16'h0064;
    tk(3);
    chk("thr_eq", 1'b1, load_enable);
    chk("power", 32'h000001F4, meas_p);
    chk("resist", 16'h0014, meas_r);
    host_u.cmd_mode = LSP_CR;
    host_u.go(1);
    chk("refuse", {1'b1, LSP_CV}, {cmd_refused, reg_mode});
    host_u.cmd_remote = 1'b1;
    host_u.go(1);
    tk(3);
    chk("mode_remote", LSP_CR, reg_mode);
    host_u.cmd_remote = 1'b0;
    meas_i = 16'h0000;
    $display("test input done");
    for (int k = 0; k < 3; k++)
      fault(k);
    $display("test protect done");
    host_u.cmd_beep_en = 1'b1;
    host_u.go(9);
    tk(3);
    chk("aux", 2'b01, {knob_en, key_sound_en});
    host_u.cmd_list = 2'h1;
    host_u.cmd_step_data = '{mode: LSP_CV, value: 16'h0011, dur_ms: DUR_MIN};
    host_u.go(5);
    host_u.cmd_step = 4'h1;
    host_u.cmd_step_data = '{mode: LSP_CR, value: 16'h0022, dur_ms: DUR_MIN};
    host_u.go(5);
    host_u.go(6);
    host_u.cmd_list_len = 4'h2;
    host_u.cmd_list_count = 8'h01;
    host_u.go(7);
    host_u.cmd_remote = 1'b1;
    host_u.cmd_input_val = 1'b1;
    host_u.go(0);
    host_u.go(8);
    tk(3);
    chk("list_go", {1'b1, 2'h1, 4'h0, LSP_CV, 16'h0011},
        {list_active, list_no, step_no, reg_mode, reg_value});
    tk(1900);
    chk("step_hold", 4'h0, step_no);
    tk(200);
    chk("step_next", {4'h1, LSP_CR, 16'h0022}, {step_no, reg_mode, reg_value});
    tk(2000);
    chk("repeat", {1'b1, 4'h0}, {list_active, step_no});
    tk(4000);
    chk("list_end", 1'b0, list_active);
    $display("test list done");
    host_u.cmd_remote = 1'b0;
    meas_i = 16'h0020;
    cmd_ocp_en = 1'b1;
    cmd_ocp_level = 16'h0010;
    cmd_ocp_delay_ms = 27'h0000004;
    cmd_ocp_set = 1'b1;
    tk(1);
    cmd_ocp_set = 1'b0;
    tk(30);
    chk("ocp_local", 1'b0, prot_latched);
    host_u.cmd_remote = 1'b1;
    cmd_ocp_set = 1'b1;
    tk(1);
    cmd_ocp_set = 1'b0;
    tk(30);
    chk("ocp_trip", {1'b1, 5'h08, 1'b1},
        {prot_latched, fault_flags, protection_summary});
    meas_i = 16'h0000;
    host_u.go(11);
    tk(3);
    chk("ocp_clear", 6'h00, {prot_latched, fault_flags});
    $display("test ocp done");
    give_verdict();
  end
endmodule : testbench

bind lsp_top lsp_chk chk_u (.*);
